// ### ppr_defs.vh
// ppr_defs.vh: constants of the process regulator
// assumes inclusion by bare name from the regulator design files
`ifndef PPR_DEFS_VH
`define PPR_DEFS_VH
// ==========================================================
// settings defaults (percent in 0.1 % steps, times in 10 ms, differential time in 1 ms)
`define PPR_TGT_SRC_RST 4'h7
`define PPR_TGT_DIG_RST 16'h01f4
`define PPR_RAMP_RST 16'h0000
`define PPR_FB_SRC_RST 4'h0
`define PPR_DIR_RST 1'b0
`define PPR_FULL_SCALE_RST 16'h03e8
`define PPR_KP_RST 16'h07d0
`define PPR_TI1_RST 16'h0050
`define PPR_TI2_RST 16'h00c8
`define PPR_TD_RST 16'h0000
`define PPR_SWMODE_RST 2'h0
`define PPR_THR_LOW_RST 16'h00c8
`define PPR_THR_HIGH_RST 16'h0320
`define PPR_IPROP_RST 8'h00
// ==========================================================
// scale: 100.0 % of a relative value
`define PPR_PCT_FULL 16'h03e8
// gain 10.00 in 0.01 units gives full frequency at full deviation
`define PPR_KP_UNIT 16'h03e8
// loop period in ns and the clock period in ns
`define PPR_LOOP_NS 2000000
`define PPR_CLK_NS 25
// ramp time unit 10 ms expressed in loop periods
`define PPR_RAMP_TICKS 5
// time unit of integral time 10 ms, differential 1 ms, in loop periods
`define PPR_TI_TICKS 5
`define PPR_TD_DIV 2
// sources
`define PPR_SRC_DIG 4'h0
`define PPR_SRC_A1 4'h1
`define PPR_SRC_A2 4'h2
`define PPR_SRC_A3 4'h3
`define PPR_SRC_PULSE 4'h4
`define PPR_SRC_COMM 4'h5
`define PPR_SRC_MULTI 4'h6
`define PPR_SRC_PRESS 4'h7
`define PPR_SW_NONE 2'h0
`define PPR_SW_INPUT 2'h1
`define PPR_SW_AUTO 2'h2
`endif

// ### ppr_gain_mix.v
// ppr_gain_mix.v: blends one gain between set one and set two
// assumes the caller gives a weight in 0..1024 (1024 means set two)
`timescale 1ns/1ps
`default_nettype none
module ppr_gain_mix #(
   parameter W = 16
) (
   input wire [W-1:0] gainOne, // value of set one
   input wire [W-1:0] gainTwo, // value of set two
   input wire [10:0] weight,   // share of set two, 1024 full
   output wire [W-1:0] gainMix // blended value
);
   // ======================================================
   // linear interpolation, done on widened signed terms
   wire signed [W+12:0] diff;
   wire signed [W+12:0] prod;
   wire signed [W+12:0] sum;
   assign diff = $signed({13'h0000, gainTwo}) - $signed({13'h0000, gainOne});
   assign prod = (diff * $signed({{(W+2){1'b0}}, weight})) >>> 10;
   assign sum = $signed({13'h0000, gainOne}) + prod;
   assign gainMix = sum[W-1:0];
endmodule
`default_nettype wire

// ### ppr_regulator.v
// ppr_regulator.v: process closed-loop regulator of a motor drive
// assumes inputs are 0..1000 (0.1 % steps), settings are steady
// ports, and the pin-level inputs are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "ppr_defs.vh"
// Functional notes
// - target chosen by selector, default pressure mode
// - target and feedback are 0..100 % values
// - target ramps linearly over set ramp time
// - feedback chosen from nine channel options
// - forward action raises output when feedback low
// - reverse action lowers output when feedback low
// - direction input inverts the selected action
// - display scaled so 100 % is full scale
// - gain 10.00 at 100 % gives max frequency
// - integral reaches max frequency after integral time
// - derivative scaled by differential time
// - two gain sets, three switchover modes
// - switch input selects set two when active
// - auto mode picks set by deviation thresholds
// - between thresholds gains are interpolated
// - integral property digits enable separation, stop
// - stop integration at output limits when enabled
// - pause input drops integral when separation valid
// - new output every 2 ms
module ppr_regulator #(
   parameter LOOP_CYC = `PPR_LOOP_NS / `PPR_CLK_NS, // 80000 cycles per loop
   parameter [15:0] FMAX = 16'h1388, // maximum frequency, 0.01 Hz
   parameter [15:0] DEF_TGT_DIG = `PPR_TGT_DIG_RST, // digital target
   parameter [3:0] DEF_TGT_SRC = `PPR_TGT_SRC_RST // target source
) (
   input wire ref_clk, // 40 MHz clock
   input wire rst, // asynchronous reset, active high
   input wire clkEn, // freezes all state while low
   input wire [3:0] targetSourceSelect, // target channel
   input wire [15:0] targetDigitalValue, // 0.1 %
   input wire [15:0] targetRampTime, // 10 ms units
   input wire [3:0] feedbackSourceSelect, // feedback channel
   input wire actionDirection, // 0 forward, 1 reverse
   input wire [15:0] displayFullScale, // display at 100 %
   input wire [15:0] propGainSetOne, // 0.01 units
   input wire [15:0] integralTimeSetOne, // 10 ms units
   input wire [15:0] derivTimeSetOne, // 1 ms units
   input wire [15:0] propGainSetTwo, // 0.01 units
   input wire [15:0] integralTimeSetTwo, // 10 ms units
   input wire [15:0] derivTimeSetTwo, // 1 ms units
   input wire [1:0] gainSwitchMode, // 0 none, 1 input, 2 auto
   input wire [15:0] switchThresholdLow, // 0.1 %
   input wire [15:0] switchThresholdHigh, // 0.1 %
   input wire [7:0] integralProperty, // bcd, units sep, tens stop
   input wire useDefaults, // high: loop idles, last settings kept
   input wire [15:0] analogInOne, // 0.1 %
   input wire [15:0] analogInTwo, // 0.1 %
   input wire [15:0] analogInThree, // 0.1 %
   input wire [15:0] pulseIn, // 0.1 %
   input wire [15:0] commValue, // 0.1 %
   input wire [15:0] multiStepValue, // 0.1 %
   input wire [15:0] pressureValue, // 0.1 %
   input wire [15:0] commFeedback, // 0.1 %
   input wire dirInvertIn, // digital input, function 35
   input wire gainSwitchIn, // digital input, function 43
   input wire integralPauseIn, // digital input, function 22
   output reg signed [16:0] freqRef, // signed, 0.01 Hz
   output reg [15:0] targetDisplay, // scaled target
   output reg [15:0] feedbackDisplay, // scaled feedback
   output reg loopTick // one cycle each new output
);
   // ======================================================
   // setting registers: defaults at reset, loaded from ports
   reg [3:0] tgtSrc_reg;
   reg [15:0] tgtDig_reg;
   reg [15:0] ramp_reg;
   reg [3:0] fbSrc_reg;
   reg dir_reg;
   reg [15:0] fullScale_reg;
   reg [15:0] kp1_reg, ti1_reg, td1_reg, kp2_reg, ti2_reg, td2_reg;
   reg [1:0] swMode_reg;
   reg [15:0] thrLo_reg, thrHi_reg;
   reg [7:0] iProp_reg;
   reg loaded_reg;
   // defaults hold until the first clock after reset; while useDefaults
   // is high the loop idles and the last settings are kept
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tgtSrc_reg <= DEF_TGT_SRC;
         tgtDig_reg <= DEF_TGT_DIG;
         ramp_reg <= `PPR_RAMP_RST;
         fbSrc_reg <= `PPR_FB_SRC_RST;
         dir_reg <= `PPR_DIR_RST;
         fullScale_reg <= `PPR_FULL_SCALE_RST;
         kp1_reg <= `PPR_KP_RST;
         ti1_reg <= `PPR_TI1_RST;
         td1_reg <= `PPR_TD_RST;
         kp2_reg <= `PPR_KP_RST;
         ti2_reg <= `PPR_TI2_RST;
         td2_reg <= `PPR_TD_RST;
         swMode_reg <= `PPR_SWMODE_RST;
         thrLo_reg <= `PPR_THR_LOW_RST;
         thrHi_reg <= `PPR_THR_HIGH_RST;
         iProp_reg <= `PPR_IPROP_RST;
         loaded_reg <= 1'b0;
      end else if (clkEn) begin
         if (useDefaults) begin
            loaded_reg <= 1'b0;
         end else begin
            loaded_reg <= 1'b1;
            tgtSrc_reg <= targetSourceSelect;
            tgtDig_reg <= targetDigitalValue;
            ramp_reg <= targetRampTime;
            fbSrc_reg <= feedbackSourceSelect;
            dir_reg <= actionDirection;
            fullScale_reg <= displayFullScale;
            kp1_reg <= propGainSetOne;
            ti1_reg <= integralTimeSetOne;
            td1_reg <= derivTimeSetOne;
            kp2_reg <= propGainSetTwo;
            ti2_reg <= integralTimeSetTwo;
            td2_reg <= derivTimeSetTwo;
            swMode_reg <= gainSwitchMode;
            thrLo_reg <= switchThresholdLow;
            thrHi_reg <= switchThresholdHigh;
            iProp_reg <= integralProperty;
         end
      end
   end

   // ======================================================
   // two-flop synchronisers for the digital input terminals
   reg [2:0] diMeta_reg, diSync_reg;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         diMeta_reg <= 3'h0;
         diSync_reg <= 3'h0;
      end else if (clkEn) begin
         diMeta_reg <= {dirInvertIn, gainSwitchIn, integralPauseIn};
         diSync_reg <= diMeta_reg;
      end
   end
   wire dirInv = diSync_reg[2];
   wire swIn = diSync_reg[1];
   wire pauseIn = diSync_reg[0];

   // ======================================================
   // source selection and clipping to 0..100 %
   function [15:0] clip;
      input [16:0] v;
      begin
         clip = (v > {1'b0, `PPR_PCT_FULL}) ? `PPR_PCT_FULL : v[15:0];
      end
   endfunction
   reg [15:0] tgtRaw, fbRaw;
   always @* begin
      case (tgtSrc_reg)
         `PPR_SRC_DIG: tgtRaw = tgtDig_reg;
         `PPR_SRC_A1: tgtRaw = analogInOne;
         `PPR_SRC_A2: tgtRaw = analogInTwo;
         `PPR_SRC_A3: tgtRaw = analogInThree;
         `PPR_SRC_PULSE: tgtRaw = pulseIn;
         `PPR_SRC_COMM: tgtRaw = commValue;
         `PPR_SRC_MULTI: tgtRaw = multiStepValue;
         `PPR_SRC_PRESS: tgtRaw = pressureValue;
         default: tgtRaw = tgtDig_reg;
      endcase
   end
   always @* begin
      case (fbSrc_reg)
         4'h0: fbRaw = analogInOne;
         4'h1: fbRaw = analogInTwo;
         4'h2: fbRaw = analogInThree;
         4'h3: fbRaw = pulseIn;
         4'h4: fbRaw = (analogInOne > analogInTwo) ?
                       analogInOne - analogInTwo : 16'h0000;
         4'h5: fbRaw = clip({1'b0, analogInOne} + {1'b0, analogInTwo});
         4'h6: fbRaw = (analogInOne > analogInTwo) ? analogInOne : analogInTwo;
         4'h7: fbRaw = (analogInOne < analogInTwo) ? analogInOne : analogInTwo;
         4'h8: fbRaw = commFeedback;
         default: fbRaw = analogInOne;
      endcase
   end
   wire [15:0] tgtIn = clip({1'b0, tgtRaw});
   wire [15:0] fbIn = clip({1'b0, fbRaw});

   // ======================================================
   // loop timer: one tick every 2 ms
   reg [16:0] loopCnt_reg;
   wire tick = (loopCnt_reg == LOOP_CYC - 1);
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loopCnt_reg <= 17'h00000;
      end else if (clkEn) begin
         loopCnt_reg <= tick ? 17'h00000 : loopCnt_reg + 17'h00001;
      end
   end

   // ======================================================
   // ramp: step per loop is 1000 / (ramp ticks), fraction kept in
   // a 32-bit remainder so the slope stays exact for long times
   reg [15:0] tgtRamp_reg;
   reg [31:0] rampAcc_reg;
   wire [31:0] rampDen = {16'h0000, ramp_reg} * `PPR_RAMP_TICKS;
   wire [31:0] rampAccNext = rampAcc_reg + {16'h0000, `PPR_PCT_FULL};
   wire [31:0] rampStep = (rampDen == 32'h0) ? 32'h0 : rampAccNext / rampDen;
   wire [31:0] rampRem = (rampDen == 32'h0) ? 32'h0 : rampAccNext % rampDen;

   // ======================================================
   // deviation, gain choice and interpolation weight
   wire signed [16:0] dev = $signed({1'b0, tgtRamp_reg}) -
                            $signed({1'b0, fbIn});
   wire signed [16:0] devNeg = -dev;
   wire [15:0] devAbs = dev[16] ? devNeg[15:0] : dev[15:0];
   reg [10:0] weight;
   reg [31:0] wq;
   always @* begin
      wq = 32'h0;
      case (swMode_reg)
         `PPR_SW_NONE: weight = 11'h000;
         `PPR_SW_INPUT: weight = swIn ? 11'h400 : 11'h000;
         `PPR_SW_AUTO: begin
            if (devAbs <= thrLo_reg) begin
               weight = 11'h000;
            end else if (devAbs >= thrHi_reg) begin
               weight = 11'h400;
            end else begin
               wq = ({16'h0000, devAbs - thrLo_reg} << 10) /
                    {16'h0000, thrHi_reg - thrLo_reg};
               weight = wq[10:0];
            end
         end
         default: weight = 11'h000;
      endcase
   end
   wire [15:0] kp, ti, td;
   ppr_gain_mix #(.W(16)) mixKp (.gainOne(kp1_reg), .gainTwo(kp2_reg),
      .weight(weight), .gainMix(kp));
   ppr_gain_mix #(.W(16)) mixTi (.gainOne(ti1_reg), .gainTwo(ti2_reg),
      .weight(weight), .gainMix(ti));
   ppr_gain_mix #(.W(16)) mixTd (.gainOne(td1_reg), .gainTwo(td2_reg),
      .weight(weight), .gainMix(td));

   // ======================================================
   // action terms in 0.01 Hz, integral kept with 16 fraction bits
   // p = kp*dev*fmax/(10.00*100.0 %)
   wire signed [47:0] pTerm = ($signed({32'h0, kp}) * dev *
      $signed({32'h0, FMAX})) / $signed(48'd1000000);
   // per loop: dev*fmax/(1000 * ti_ticks), scaled by 2^16
   wire [31:0] tiDen = (ti == 16'h0) ? 32'h1 : {16'h0000, ti} * `PPR_TI_TICKS;
   wire signed [47:0] iStep = ($signed({{31{dev[16]}}, dev}) *
      $signed({32'h0, FMAX}) * 48'sd65536) /
      ($signed({16'h0, tiDen}) * 48'sd1000);
   // d = -dfb * fmax * td(ms) / (1000 * 2 ms)
   reg [15:0] fbPrev_reg;
   wire signed [16:0] dFb = $signed({1'b0, fbIn}) - $signed({1'b0, fbPrev_reg});
   wire signed [47:0] dTerm = -($signed({{31{dFb[16]}}, dFb}) *
      $signed({32'h0, FMAX}) * $signed({32'h0, td})) /
      $signed(48'd2000);
   reg signed [47:0] iAcc_reg;
   wire sepValid = (iProp_reg[3:0] == 4'h1);
   wire stopAtLim = (iProp_reg[7:4] == 4'h1);
   wire useI = !(sepValid && pauseIn);
   wire signed [47:0] fmaxS = $signed({32'h0, FMAX});
   wire signed [47:0] sumRaw = pTerm + (useI ? (iAcc_reg >>> 16) : 48'sd0) +
      dTerm;
   // direction: reverse or inverted input, but not both, negates the action
   wire neg = dir_reg ^ dirInv;
   wire signed [47:0] sumDir = neg ? -sumRaw : sumRaw;
   wire atMax = (sumDir >= fmaxS);
   wire atMin = (sumDir <= -fmaxS);
   wire signed [47:0] outClamp = atMax ? fmaxS : (atMin ? -fmaxS : sumDir);
   // display products; 100 % of any scale still fits in 16 bits
   wire [31:0] tDispW = ({16'h0, tgtRamp_reg} * {16'h0, fullScale_reg}) /
      32'd1000;
   wire [31:0] fDispW = ({16'h0, fbIn} * {16'h0, fullScale_reg}) / 32'd1000;

   // ======================================================
   // loop update: ramp, integral, history and outputs
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tgtRamp_reg <= 16'h0000;
         rampAcc_reg <= 32'h0;
         iAcc_reg <= 48'sd0;
         fbPrev_reg <= 16'h0000;
         freqRef <= 17'sd0;
         targetDisplay <= 16'h0000;
         feedbackDisplay <= 16'h0000;
         loopTick <= 1'b0;
      end else if (clkEn) begin
         loopTick <= tick && loaded_reg;
         if (tick && loaded_reg) begin
            // ramp toward the selected target; zero time jumps
            if (rampDen == 32'h0) begin
               tgtRamp_reg <= tgtIn;
               rampAcc_reg <= 32'h0;
            end else if (tgtRamp_reg < tgtIn) begin
               rampAcc_reg <= rampRem;
               tgtRamp_reg <= ({16'h0, tgtIn - tgtRamp_reg} <= rampStep) ?
                  tgtIn : tgtRamp_reg + rampStep[15:0];
            end else if (tgtRamp_reg > tgtIn) begin
               rampAcc_reg <= rampRem;
               tgtRamp_reg <= ({16'h0, tgtRamp_reg - tgtIn} <= rampStep) ?
                  tgtIn : tgtRamp_reg - rampStep[15:0];
            end else begin
               rampAcc_reg <= 32'h0;
            end
            // frozen at the limits when stop is selected
            if (useI && !(stopAtLim && (atMax || atMin))) begin
               iAcc_reg <= iAcc_reg + iStep;
            end
            fbPrev_reg <= fbIn;
            freqRef <= outClamp[16:0];
            targetDisplay <= tDispW[15:0];
            feedbackDisplay <= fDispW[15:0];
         end
      end
   end
endmodule
`default_nettype wire

// ### ppr_regulator_monitor.sv
// ppr_regulator_monitor.sv: port-level timing and range checks of the regulator
// assumes the bind at the foot and one clock domain
`timescale 1ns/1ps
`default_nettype none
module ppr_regulator_monitor #(
   parameter LOOP_CYC = 20,
   parameter [15:0] FMAX = 16'h1388
) (
   input wire ref_clk, // loop clock
   input wire rst, // async reset
   input wire clkEn, // state enable
   input wire useDefaults, // idle request
   input wire [15:0] displayFullScale, // display scale
   input wire signed [16:0] freqRef, // regulator output
   input wire [15:0] targetDisplay, // scaled target
   input wire [15:0] feedbackDisplay, // scaled feedback
   input wire loopTick // update pulse
);
   reg [31:0] gapReg;
   reg cleanReg;
   // ==========
   // gap between ticks; a pause or idle spoils the gap being measured
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gapReg <= 32'h0;
         cleanReg <= 1'b0;
      end else begin
         gapReg <= loopTick ? 32'h1 : gapReg + 32'h1;
         cleanReg <= loopTick | (cleanReg & clkEn & ~useDefaults);
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_tick_pulse;
      loopTick |=> !loopTick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse)
      else $error("tick pulse too long");
   property p_tick_gap;
      loopTick && cleanReg |-> gapReg == LOOP_CYC;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("loop period wrong");
   property p_hold;
      !loopTick |-> $stable(freqRef) && $stable(targetDisplay)
         && $stable(feedbackDisplay);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output moved between ticks");
   property p_clamp;
      freqRef <= $signed({1'b0, FMAX}) && freqRef >= -$signed({1'b0, FMAX});
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("output beyond limit");
   property p_idle;
      useDefaults && $past(useDefaults) && $past(useDefaults, 2)
         |-> !loopTick;
   endproperty
   a_idle: assert property (p_idle)
      else $error("tick while idle");
   property p_fs_zero;
      loopTick && $past(displayFullScale, 2) == 16'h0
         |-> targetDisplay == 16'h0 && feedbackDisplay == 16'h0;
   endproperty
   a_fs_zero: assert property (p_fs_zero)
      else $error("display not zero at zero scale");
   property p_fs_full;
      loopTick && $past(displayFullScale, 2) == 16'h3e8
         |-> targetDisplay <= 16'h3e8 && feedbackDisplay <= 16'h3e8;
   endproperty
   a_fs_full: assert property (p_fs_full)
      else $error("display above full scale");
   property p_reset;
      $fell(rst) |-> (freqRef == 17'sh0 && !loopTick)[*8];
   endproperty
   a_reset: assert property (p_reset)
      else $error("output not cleared by reset");
endmodule
bind ppr_regulator ppr_regulator_monitor #(.LOOP_CYC(LOOP_CYC), .FMAX(FMAX))
   ppr_regulator_monitor_inst (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
   .useDefaults(useDefaults), .displayFullScale(displayFullScale),
   .freqRef(freqRef), .targetDisplay(targetDisplay),
   .feedbackDisplay(feedbackDisplay), .loopTick(loopTick));
`default_nettype wire

// ### ppr_field_model.sv
// ppr_field_model.sv: sensors and terminals in front of the regulator
// assumes the bench calls its tasks; levels are 0..1000 steps of 0.1 %
`timescale 1ns/1ps
`default_nettype none
module ppr_field_model (
   input wire ref_clk, // loop clock
   output reg [15:0] anOne, // analog channel one
   output reg [15:0] anTwo, // analog channel two
   output reg [15:0] anThree, // analog channel three
   output reg [15:0] pulseLvl, // pulse input level
   output reg dInv, // terminal, direction inversion
   output reg dSw, // terminal, gain switchover
   output reg dPause // terminal, integral pause
);
   initial begin
      {anOne, anTwo, anThree, pulseLvl} = 64'h0;
      {dInv, dSw, dPause} = 3'h0;
   end
   // sensors saturate at full scale
   function [15:0] clip(input [15:0] v);
      clip = (v > 16'h03e8) ? 16'h03e8 : v;
   endfunction
   // ==========
   // levels move with the clock, as the converters are clocked
   task set_analog(input [15:0] a, b, c, p);
      begin
         @(posedge ref_clk);
         anOne <= clip(a);
         anTwo <= clip(b);
         anThree <= clip(c);
         pulseLvl <= clip(p);
      end
   endtask
   // contacts switch off the edge; the design must synchronise them
   task set_terminals(input i, s, q);
      begin
         @(posedge ref_clk);
         #7 {dInv, dSw, dPause} = {i, s, q};
      end
   endtask
endmodule
`default_nettype wire

// ### ppr_regulator_tb.sv
// ppr_regulator_tb.sv: self-checking bench of the process regulator
// assumes a short loop period parameter so each loop is 20 clocks
`timescale 1ns/1ps
`default_nettype none
module ppr_regulator_tb;
   localparam LOOP = 20;
   reg ref_clk = 1'b0;
   reg rst = 1'b1;
   reg [3:0] tSel = 4'h0, fSel = 4'h0;
   reg dir = 1'b0, useDef = 1'b0;
   reg [1:0] swMode = 2'h0;
   reg [15:0] tDig = 16'h0, ramp = 16'h0, fs = 16'h3e8, ti = 16'h3e8;
   reg [15:0] kp1 = 16'h0, kp2 = 16'h0, comm = 16'h0, commFb = 16'h0;
   reg [15:0] multi = 16'h0, press = 16'h0, td = 16'h0;
   reg [7:0] iProp = 8'h00;
   reg [31:0] seed = 32'h7861285f;
   reg [15:0] v [0:3];
   wire [15:0] a1, a2, a3, pl, tDisp, fDisp;
   wire dInv, dSw, dPause, tick;
   wire signed [16:0] freq;
   integer badCount = 0, numChecks = 0, n, j, c;
   always #12.5 ref_clk = ~ref_clk;
   ppr_regulator #(.LOOP_CYC(LOOP)) ppr_regulator_inst (.ref_clk(ref_clk),
      .rst(rst), .clkEn(1'b1), .targetSourceSelect(tSel),
      .targetDigitalValue(tDig), .targetRampTime(ramp),
      .feedbackSourceSelect(fSel), .actionDirection(dir),
      .displayFullScale(fs), .propGainSetOne(kp1), .integralTimeSetOne(ti),
      .derivTimeSetOne(td), .propGainSetTwo(kp2), .integralTimeSetTwo(ti),
      .derivTimeSetTwo(16'h0), .gainSwitchMode(swMode),
      .switchThresholdLow(16'h00c8), .switchThresholdHigh(16'h0320),
      .integralProperty(iProp), .useDefaults(useDef), .analogInOne(a1),
      .analogInTwo(a2), .analogInThree(a3), .pulseIn(pl), .commValue(comm),
      .multiStepValue(multi), .pressureValue(press), .commFeedback(commFb),
      .dirInvertIn(dInv), .gainSwitchIn(dSw), .integralPauseIn(dPause),
      .freqRef(freq), .targetDisplay(tDisp), .feedbackDisplay(fDisp),
      .loopTick(tick));
   ppr_field_model ppr_field_model_inst (.ref_clk(ref_clk), .anOne(a1),
      .anTwo(a2), .anThree(a3), .pulseLvl(pl), .dInv(dInv), .dSw(dSw),
      .dPause(dPause));
   // ==========
   // expectations; xorshift keeps the run repeatable
   function [15:0] pct(input integer u);
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         pct = 16'(seed % 32'd1001);
      end
   endfunction
   function [15:0] scale(input [15:0] x);
      scale = 16'((32'(x) * 32'(fs)) / 32'd1000);
   endfunction
   function [15:0] tgtExp(input [3:0] s);
      case (s)
         4'h0: tgtExp = tDig;
         4'h5: tgtExp = comm;
         4'h6: tgtExp = multi;
         4'h7: tgtExp = press;
         default: tgtExp = v[s - 4'h1];
      endcase
   endfunction
   function [15:0] fbExp(input [3:0] s);
      case (s)
         4'h4: fbExp = (v[0] > v[1]) ? v[0] - v[1] : 16'h0;
         4'h5: fbExp = (v[0] + v[1] > 16'h3e8) ? 16'h3e8 : v[0] + v[1];
         4'h6: fbExp = (v[0] > v[1]) ? v[0] : v[1];
         4'h7: fbExp = (v[0] < v[1]) ? v[0] : v[1];
         4'h8: fbExp = commFb;
         default: fbExp = v[s[1:0]];
      endcase
   endfunction
   // ==========
   // shared checks and waits
   task check(input [31:0] got, exp);
      begin
         numChecks = numChecks + 1;
         if (got !== exp) begin
            badCount = badCount + 1;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
         end
      end
   endtask
   task inRange(input [16:0] got, input integer lo, hi);
      begin
         numChecks = numChecks + 1;
         if (^got === 1'bx || $signed(got) < lo || $signed(got) > hi) begin
            badCount = badCount + 1;
            $display("wrong value at %0t: %h expected %h..%h", $time, got,
               lo, hi);
         end
      end
   endtask
   task tallyAndFinish;
      begin
         $display("checks %0d mismatches %0d", numChecks, badCount);
         if (badCount == 0 && numChecks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // a missing tick is fatal to the run, so it ends the report early
   task waitTicks(input integer k);
      integer m;
      begin
         for (m = 0; m < k; m = m + 1) begin
            c = 0;
            @(negedge ref_clk);
            while (tick !== 1'b1 && c < 3 * LOOP) begin
               @(negedge ref_clk);
               c = c + 1;
            end
            check(tick, 1'b1);
            if (tick !== 1'b1)
               tallyAndFinish;
         end
      end
   endtask
   task doReset;
      begin
         @(posedge ref_clk);
         rst <= 1'b1;
         repeat (4) @(posedge ref_clk);
         rst <= 1'b0;
      end
   endtask
   // fresh integral each case; the first loop after reset still sees
   // the cleared target, so the output of the second is judged
   task runCase(input [1:0] m, input s, d, i, q, input [15:0] k1, k2, t,
         f, input integer lo, hi);
      begin
         ppr_field_model_inst.set_terminals(i, s, q);
         ppr_field_model_inst.set_analog(f, 16'h0, 16'h0, 16'h0);
         swMode <= m;
         dir <= d;
         kp1 <= k1;
         kp2 <= k2;
         tDig <= t;
         doReset;
         waitTicks(2);
         inRange(freq, lo, hi);
         $display("case done, output %0d", freq);
      end
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      runCase(0, 0, 0, 0, 0, 100, 0, 500, 0, 250, 251);
      runCase(0, 0, 1, 0, 0, 100, 0, 500, 0, -251, -250);
      runCase(0, 0, 0, 1, 0, 100, 0, 500, 0, -251, -250);
      runCase(0, 0, 1, 1, 0, 100, 0, 500, 0, 250, 251);
      runCase(0, 0, 0, 0, 0, 100, 0, 0, 500, -251, -250);
      runCase(0, 0, 0, 0, 0, 1000, 0, 1000, 0, 5000, 5000);
      runCase(1, 0, 0, 0, 0, 0, 100, 500, 0, 0, 1);
      runCase(1, 1, 0, 0, 0, 0, 100, 500, 0, 250, 251);
      runCase(0, 1, 0, 0, 0, 0, 100, 500, 0, 0, 1);
      runCase(2, 0, 0, 0, 0, 0, 100, 100, 0, 0, 1);
      runCase(2, 0, 0, 0, 0, 0, 100, 900, 0, 450, 451);
      runCase(2, 0, 0, 0, 0, 0, 100, 500, 0, 124, 127);
      // every target and feedback channel, random levels; scale zero, full, then random
      for (n = 0; n < 9; n = n + 1) begin
         for (j = 0; j < 4; j = j + 1)
            v[j] = pct(j);
         ppr_field_model_inst.set_analog(v[0], v[1], v[2], v[3]);
         tSel <= n[3:0] & 4'h7;
         fSel <= n[3:0];
         fs <= (n == 0) ? 16'h0 : (n == 1) ? 16'h3e8 : pct(0) * 16'h41;
         tDig <= pct(0);
         comm <= pct(0);
         multi <= pct(0);
         press <= pct(0);
         commFb <= pct(0);
         waitTicks(2);
         check(tDisp, scale(tgtExp(n[3:0] & 4'h7)));
         check(fDisp, scale(fbExp(n[3:0])));
      end
      $display("channel scan done");
      // ramp of 20 ms is ten loops of one tenth each
      @(posedge ref_clk);
      tSel <= 4'h0;
      fSel <= 4'h0;
      fs <= 16'h3e8;
      tDig <= 16'h0;
      waitTicks(2);
      @(posedge ref_clk);
      ramp <= 16'h2;
      tDig <= 16'h3e8;
      waitTicks(5);
      inRange({1'b0, tDisp}, 300, 600);
      check(tDisp % 16'd100, 16'h0);
      waitTicks(8);
      check(tDisp, 16'h3e8);
      $display("ramp done");
      // integral alone; pause ignored while separation is off
      @(posedge ref_clk);
      ramp <= 16'h0;
      ti <= 16'h1;
      iProp <= 8'h10;
      runCase(0, 0, 0, 0, 1, 0, 0, 1000, 0, 0, 1000);
      waitTicks(2);
      inRange(freq, 2000, 3000);
      waitTicks(7);
      ppr_field_model_inst.set_analog(16'h3e8, 16'h0, 16'h0, 16'h0);
      tDig <= 16'h0;
      waitTicks(3);
      // accumulator frozen at the limit, no gain left to pull it back
      inRange(freq, 5000, 5000);
      @(posedge ref_clk);
      iProp <= 8'h11;
      runCase(0, 0, 0, 0, 1, 0, 0, 1000, 0, 0, 0);
      waitTicks(2);
      inRange(freq, 0, 0);
      // feedback step of 10 % with 10 ms: only the derivative acts
      ppr_field_model_inst.set_analog(16'h64, 16'h0, 16'h0, 16'h0);
      td <= 16'ha;
      waitTicks(1);
      inRange(freq, -2500, -2500);
      // default request keeps the loop idle
      @(posedge ref_clk);
      useDef <= 1'b1;
      c = 0;
      repeat (2) @(negedge ref_clk);
      repeat (3 * LOOP) @(negedge ref_clk) c = c + tick;
      check(c, 0);
      @(posedge ref_clk);
      useDef <= 1'b0;
      waitTicks(2);
      $display("integral and idle done");
      tallyAndFinish;
   end
endmodule
`default_nettype wire
